// ---- logic/compass_defs.svh ----
`ifndef COMPASS_DEFS_SVH
`define COMPASS_DEFS_SVH

// ********************************************************
// Timing
// ********************************************************
`define CLK_PERIOD_NS   100000 / 10000
`define I2C_BIT_NS      10000
`define QTR_CYCLES      ((`I2C_BIT_NS / 4) / (`CLK_PERIOD_NS))
`define MS_NS           1000000
`define MS_PER_S        1000
`define SR_PERIOD_MS    180000

// ********************************************************
// Addresses and fixed values
// ********************************************************
`define DEV_ADDR_W      8'h42
`define MODE_ADDR       8'h74
`define EE_MODE_ADDR    8'h08
`define MODE_RESET      8'h00
`define IDLE_BYTE       8'hFF

// ********************************************************
// Mode byte fields
// ********************************************************
`define MODE_OP_HI      1
`define MODE_OP_LO      0
`define MODE_PSR        4
`define MODE_RATE_HI    6
`define MODE_RATE_LO    5
`define OP_STANDBY      2'h0
`define OP_QUERY        2'h1
`define OP_CONT         2'h2
`define RATE_0_HZ       1
`define RATE_1_HZ       5
`define RATE_2_HZ       10
`define RATE_3_HZ       20

// ********************************************************
// Command codes
// ********************************************************
`define CMD_WRITE_WAKE  8'h57
`define CMD_EE_RD       8'h52
`define CMD_RAM_WR      8'h47
`define CMD_RAM_RD      8'h67
`define CMD_SLEEP       8'h53
`define CMD_SR_NOW      8'h4F
`define CMD_CAL_IN      8'h43
`define CMD_CAL_OUT     8'h45
`define CMD_SAVE        8'h4C
`define CMD_GET         8'h41

`endif

// ---- logic/compass_pkg.sv ----
package compass_pkg;
	typedef logic [7:0]  byte_type;
	typedef logic [15:0] word_type;
	typedef logic [23:0] cmd_bytes_type;
	typedef enum logic [1:0] {EV_CMD, EV_ARG, EV_EXEC, EV_RDONE} ev_kind_type;
	typedef enum logic [1:0] {CTX_NONE, CTX_BYTE, CTX_DATA} ctx_type;
	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_AACK, L_RX, L_RACK, L_TX, L_TACK} link_state_type;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_type;
endpackage : compass_pkg

// ---- logic/compass_i2c_if.sv ----
`timescale 1ns/1ps
interface compass_i2c_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wired levels with pull-ups
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
	modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface : compass_i2c_if

// ---- logic/compass_dev.sv ----
`timescale 1ns/1ps
`include "compass_defs.svh"
module compass_dev #(
	parameter int TICK_CYCLES  = `MS_NS / (`CLK_PERIOD_NS),
	parameter int SR_PERIOD_MS = `SR_PERIOD_MS
) (
	// Core clock, reset, enable
	input  wire logic                 MCLK,
	input  wire logic                 NRST,
	input  wire logic                 CE,
	// Link oversampling clock
	input  wire logic                 LCLK,
	// Two-wire link
	compass_i2c_if.dev                I2C,
	// Measurement engine
	output logic                      MEAS_REQ,
	input  wire logic                 MEAS_DONE,
	input  wire compass_pkg::word_type MEAS_DATA,
	// Nonvolatile store
	output logic                      EE_WE,
	output logic                      EE_RE,
	output compass_pkg::byte_type     EE_ADDR,
	output compass_pkg::byte_type     EE_WDATA,
	input  wire compass_pkg::byte_type EE_RDATA,
	// Sensor control
	output logic                      SLEEP,
	output logic                      SR_PULSE,
	output logic                      CAL_MODE,
	output compass_pkg::byte_type     OP_MODE
);
	import compass_pkg::*;

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic byte_type tx_byte(word_type w, logic [1:0] n, logic [1:0] i);
		if (i >= n) return `IDLE_BYTE;
		return (i == 2'h0) ? w[15:8] : w[7:0];
	endfunction : tx_byte

	function automatic logic [9:0] rate_ms(logic [1:0] sel);
		unique case (sel)
			2'h0: return 10'(`MS_PER_S / `RATE_0_HZ);
			2'h1: return 10'(`MS_PER_S / `RATE_1_HZ);
			2'h2: return 10'(`MS_PER_S / `RATE_2_HZ);
			2'h3: return 10'(`MS_PER_S / `RATE_3_HZ);
		endcase
	endfunction : rate_ms

	function automatic logic [1:0] rsp_len(ctx_type c);
		return (c == CTX_DATA) ? 2'h2 : (c == CTX_BYTE) ? 2'h1 : 2'h0;
	endfunction : rsp_len

	// ********************************************************
	// Link domain
	// ********************************************************
	logic           lrst_m, lrst_n;
	logic           scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic           pt_m, pt_s, pt_d;
	word_type       rsp_l, snap_r;
	logic [1:0]     cnt_l, scnt_r, idx_r;
	link_state_type lst_r;
	logic [2:0]     bit_r;
	byte_type       sh_r, load_c, ev_data_r;
	ev_kind_type    ev_kind_r;
	logic           ev_tog_r, got_r, rw_r, first_r, wrf_r, rdf_r, oe_r;
	logic           rise, fall, start_c, stop_c;
	// Core-side signals seen by the link
	logic           pub_tog_r;
	word_type       pub_word_r;
	logic [1:0]     pub_cnt_r;

	// Reset release synchronised to the link clock
	always_ff @(posedge LCLK or negedge NRST) begin
		if (!NRST) begin
			lrst_m <= 1'h0;
			lrst_n <= 1'h0;
		end else begin
			lrst_m <= 1'h1;
			lrst_n <= lrst_m;
		end
	end

	// Pin synchronisers and response word crossing
	always_ff @(posedge LCLK or negedge lrst_n) begin
		if (!lrst_n) begin
			{scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
			{pt_m, pt_s, pt_d} <= 3'h0;
			rsp_l <= 16'h0000;
			cnt_l <= 2'h0;
		end else begin
			scl_m <= I2C.scl;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= I2C.sda;
			sda_s <= sda_m;
			sda_d <= sda_s;
			pt_m  <= pub_tog_r;
			pt_s  <= pt_m;
			pt_d  <= pt_s;
			if (pt_s ^ pt_d) begin
				rsp_l <= pub_word_r;
				cnt_l <= pub_cnt_r;
			end
		end
	end

	// Line events from the oversampled pins
	assign rise    = scl_s & ~scl_d;
	assign fall    = ~scl_s & scl_d;
	assign start_c = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c  = scl_s & scl_d & ~sda_d & sda_s;
	assign load_c  = (lst_r == L_AACK) ? tx_byte(rsp_l, cnt_l, 2'h0) : tx_byte(snap_r, scnt_r, idx_r);

	// Slave byte engine
	always_ff @(posedge LCLK or negedge lrst_n) begin
		if (!lrst_n) begin
			lst_r <= L_IDLE;
			{bit_r, sh_r, got_r, rw_r, first_r, wrf_r, rdf_r, oe_r} <= 17'h00000;
			{ev_tog_r, ev_data_r, idx_r, snap_r, scnt_r} <= 29'h0000000;
			ev_kind_r <= EV_CMD;
		end else if (start_c | stop_c) begin
			if (wrf_r) begin
				ev_kind_r <= EV_EXEC;
				ev_tog_r  <= ~ev_tog_r;
			end else if (rdf_r) begin
				ev_kind_r <= EV_RDONE;
				ev_tog_r  <= ~ev_tog_r;
			end
			{wrf_r, rdf_r, oe_r, got_r, bit_r} <= 7'h00;
			first_r <= 1'h1;
			lst_r   <= start_c ? L_ADDR : L_IDLE;
		end else begin
			unique case (lst_r)
				L_IDLE: ;
				L_ADDR, L_RX: begin
					if (rise) begin
						sh_r  <= {sh_r[6:0], sda_s};
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7)
							got_r <= 1'h1;
					end else if (fall && got_r) begin
						got_r <= 1'h0;
						if (lst_r == L_RX) begin
							oe_r      <= 1'h1;
							lst_r     <= L_RACK;
							ev_kind_r <= first_r ? EV_CMD : EV_ARG;
							ev_data_r <= sh_r;
							ev_tog_r  <= ~ev_tog_r;
							first_r   <= 1'h0;
							wrf_r     <= 1'h1;
						end else if ({sh_r[7:1], 1'h0} == `DEV_ADDR_W) begin
							oe_r  <= 1'h1;
							rw_r  <= sh_r[0];
							lst_r <= L_AACK;
						end else
							lst_r <= L_IDLE;
					end
				end
				L_AACK: if (fall) begin
					if (rw_r) begin
						sh_r   <= load_c;
						oe_r   <= ~load_c[7];
						snap_r <= rsp_l;
						scnt_r <= cnt_l;
						idx_r  <= 2'h1;
						rdf_r  <= 1'h1;
						lst_r  <= L_TX;
					end else begin
						oe_r  <= 1'h0;
						lst_r <= L_RX;
					end
				end
				L_RACK: if (fall) begin
					oe_r  <= 1'h0;
					lst_r <= L_RX;
				end
				L_TX: begin
					if (rise) begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7)
							got_r <= 1'h1;
					end else if (fall) begin
						if (got_r) begin
							got_r <= 1'h0;
							oe_r  <= 1'h0;
							lst_r <= L_TACK;
						end else begin
							sh_r <= {sh_r[6:0], 1'h0};
							oe_r <= ~sh_r[6];
						end
					end
				end
				L_TACK: begin
					if (rise) begin
						if (sda_s)
							lst_r <= L_IDLE;
						else
							got_r <= 1'h1;
					end else if (fall && got_r) begin
						got_r <= 1'h0;
						sh_r  <= load_c;
						oe_r  <= ~load_c[7];
						if (idx_r != 2'h3)
							idx_r <= idx_r + 2'h1;
						lst_r <= L_TX;
					end
				end
			endcase
		end
	end

	// Open-drain data pin
	assign I2C.dev_sda_o  = 1'h0;
	assign I2C.dev_sda_oe = oe_r;

	// ********************************************************
	// Core domain
	// ********************************************************
	logic          et_m, et_s, et_d, ak_m, ak_s;
	logic          new_ev, exec, busy_p, ms_tick, rate_hit, per_sr, want, issue;
	logic          boot_r, bootrd_r, eeb_r, eec_r, sleep_r, cal_r, busy_r, pend_r;
	logic          do_eew, do_eer, do_ramw, do_ramr, do_sleep, do_wake, do_sr, do_cin, do_cout, do_save, do_get;
	byte_type      cmd_r, a1_r, a2_r, mode_r, byte_r;
	byte_type      ram_mem [256];
	logic [1:0]    nb_r, op;
	ctx_type       ctx_r;
	word_type      meas_r, dw;
	logic [31:0]   tk_r, sr_r;
	logic [9:0]    rt_r;

	assign new_ev   = et_s ^ et_d;
	assign exec     = new_ev && (ev_kind_r == EV_EXEC);
	assign busy_p   = pub_tog_r ^ ak_s;
	assign op       = mode_r[`MODE_OP_HI:`MODE_OP_LO];
	assign ms_tick  = (tk_r == 32'(TICK_CYCLES - 1));
	assign rate_hit = ms_tick && (rt_r == rate_ms(mode_r[`MODE_RATE_HI:`MODE_RATE_LO]) - 10'h001);
	assign per_sr   = ms_tick && mode_r[`MODE_PSR] && (sr_r == 32'(SR_PERIOD_MS - 1));
	assign dw       = (ctx_r == CTX_DATA) ? meas_r : {byte_r, `IDLE_BYTE};
	// Standby and forbidden code wait for get-data only
	assign want     = do_get || (op == `OP_QUERY && exec == 1'h0 && new_ev && ev_kind_r == EV_RDONE
	                  && ctx_r == CTX_DATA) || (op == `OP_CONT && rate_hit);
	assign issue    = (want | pend_r) & ~busy_r & ~sleep_r;

	// Command decode on the end of a write
	always_comb begin
		{do_eew, do_eer, do_ramw, do_ramr, do_sleep, do_wake, do_sr, do_cin, do_cout, do_save, do_get} = 11'h000;
		if (exec) begin
			unique case (cmd_r)
				`CMD_WRITE_WAKE: if (nb_r == 2'h3) do_eew = 1'h1; else do_wake = 1'h1;
				`CMD_EE_RD:      do_eer   = (nb_r >= 2'h2);
				`CMD_RAM_WR:     do_ramw  = (nb_r == 2'h3);
				`CMD_RAM_RD:     do_ramr  = (nb_r >= 2'h2);
				`CMD_SLEEP:      do_sleep = 1'h1;
				`CMD_SR_NOW:     do_sr    = 1'h1;
				`CMD_CAL_IN:     do_cin   = 1'h1;
				`CMD_CAL_OUT:    do_cout  = 1'h1;
				`CMD_SAVE:       do_save  = 1'h1;
				`CMD_GET:        do_get   = 1'h1;
				default: ;
			endcase
		end
	end

	// Synchronisers and command byte capture
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			{et_m, et_s, et_d, ak_m, ak_s} <= 5'h00;
			{cmd_r, a1_r, a2_r} <= 24'h000000;
			nb_r <= 2'h0;
		end else if (CE) begin
			et_m <= ev_tog_r;
			et_s <= et_m;
			et_d <= et_s;
			ak_m <= pt_d;
			ak_s <= ak_m;
			if (new_ev && ev_kind_r == EV_CMD) begin
				cmd_r <= ev_data_r;
				nb_r  <= 2'h1;
			end else if (new_ev && ev_kind_r == EV_ARG) begin
				if (nb_r == 2'h1) a1_r <= ev_data_r;
				if (nb_r == 2'h2) a2_r <= ev_data_r;
				if (nb_r != 2'h3) nb_r <= nb_r + 2'h1;
			end
		end
	end

	// RAM registers other than the mode byte
	always_ff @(posedge MCLK) begin
		if (CE && do_ramw && a1_r != `MODE_ADDR)
			ram_mem[a1_r] <= a2_r;
	end

	// Mode byte, sleep, calibration, read context
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			mode_r <= `MODE_RESET;
			{sleep_r, cal_r} <= 2'h0;
			ctx_r  <= CTX_NONE;
			byte_r <= 8'h00;
		end else if (CE) begin
			if (eeb_r) mode_r <= EE_RDATA;
			else if (do_ramw && a1_r == `MODE_ADDR) mode_r <= a2_r;
			if (do_sleep) sleep_r <= 1'h1; else if (do_wake) sleep_r <= 1'h0;
			if (do_cin) cal_r <= 1'h1; else if (do_cout) cal_r <= 1'h0;
			if (do_get) ctx_r <= CTX_DATA;
			else if (do_eer | do_ramr) ctx_r <= CTX_BYTE;
			else if (do_eew | do_ramw | do_sleep | do_wake | do_sr | do_cin | do_cout | do_save) ctx_r <= CTX_NONE;
			if (do_ramr) byte_r <= (a1_r == `MODE_ADDR) ? mode_r : ram_mem[a1_r];
			else if (eec_r) byte_r <= EE_RDATA;
		end
	end

	// Nonvolatile store access, power-up mode load first
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			{boot_r, eeb_r, eec_r, EE_WE, EE_RE} <= 5'h10;
			bootrd_r <= 1'h0;
			{EE_ADDR, EE_WDATA} <= 16'h0000;
		end else if (CE) begin
			boot_r   <= 1'h0;
			// Marks the read issued by the power-up load, one cycle behind the request
			bootrd_r <= boot_r;
			eeb_r    <= EE_RE & bootrd_r;
			eec_r    <= EE_RE & ~bootrd_r;
			EE_WE    <= do_eew | do_save;
			EE_RE    <= boot_r | do_eer;
			EE_ADDR  <= (boot_r | do_save) ? `EE_MODE_ADDR : a1_r;
			EE_WDATA <= do_save ? mode_r : a2_r;
		end
	end

	// Measurement requests and results
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			{MEAS_REQ, busy_r, pend_r, SR_PULSE} <= 4'h0;
			meas_r <= 16'h0000;
		end else if (CE) begin
			MEAS_REQ <= issue;
			busy_r   <= issue | (busy_r & ~MEAS_DONE);
			pend_r   <= (want | pend_r) & ~issue;
			SR_PULSE <= do_sr | per_sr;
			if (MEAS_DONE) meas_r <= MEAS_DATA;
		end
	end

	// Millisecond tick, rate and periodic set/reset timers
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			{tk_r, sr_r} <= 64'h0000000000000000;
			rt_r <= 10'h000;
		end else if (CE) begin
			tk_r <= ms_tick ? 32'h00000000 : tk_r + 32'h00000001;
			if (do_get || op != `OP_CONT) rt_r <= 10'h000;
			else if (ms_tick) rt_r <= rate_hit ? 10'h000 : rt_r + 10'h001;
			if (!mode_r[`MODE_PSR]) sr_r <= 32'h00000000;
			else if (ms_tick) sr_r <= per_sr ? 32'h00000000 : sr_r + 32'h00000001;
		end
	end

	// Publish the read response to the link
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			pub_tog_r  <= 1'h0;
			pub_word_r <= 16'h0000;
			pub_cnt_r  <= 2'h0;
		end else if (CE && !busy_p && (dw != pub_word_r || rsp_len(ctx_r) != pub_cnt_r)) begin
			pub_word_r <= dw;
			pub_cnt_r  <= rsp_len(ctx_r);
			pub_tog_r  <= ~pub_tog_r;
		end
	end

	assign SLEEP    = sleep_r;
	assign CAL_MODE = cal_r;
	assign OP_MODE  = mode_r;
endmodule : compass_dev

// ---- logic/compass_host.sv ----
`timescale 1ns/1ps
`include "compass_defs.svh"
module compass_host (
	// Clock, reset, enable
	input  wire logic                      MCLK,
	input  wire logic                      NRST,
	input  wire logic                      CE,
	// Two-wire link
	compass_i2c_if.host                    I2C,
	// Transfer request
	input  wire logic                      CMD_VALID,
	output logic                           CMD_READY,
	input  wire logic                      CMD_READ,
	input  wire logic [1:0]                CMD_LEN,
	input  wire compass_pkg::cmd_bytes_type CMD_DATA,
	// Transfer result
	output logic                           RSP_VALID,
	output compass_pkg::word_type          RSP_DATA,
	output logic                           RSP_NACK
);
	import compass_pkg::*;

	function automatic byte_type pick(cmd_bytes_type d, logic [1:0] i);
		return (i == 2'h1) ? d[23:16] : (i == 2'h2) ? d[15:8] : d[7:0];
	endfunction : pick

	host_state_type hst_r;
	logic [8:0]     q_r;
	logic [1:0]     ph_r, byt_r, len_r;
	logic [3:0]     bit_r;
	logic           rd_r, nack_r, scl_oe_r, sda_oe_r, sm, ss, qt, out_c;
	byte_type       sh_r;
	cmd_bytes_type  dat_r;
	word_type       rx_r;

	// Quarter-bit tick: four per bit at the standard-mode rate
	assign qt        = (q_r == 9'(`QTR_CYCLES - 1));
	assign out_c     = (byt_r == 2'h0) || !rd_r;
	assign CMD_READY = (hst_r == H_IDLE);

	// Data pin synchroniser and tick counter
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			{sm, ss} <= 2'h3;
			q_r <= 9'h000;
		end else if (CE) begin
			sm  <= I2C.sda;
			ss  <= sm;
			q_r <= qt ? 9'h000 : q_r + 9'h001;
		end
	end

	// Master frame sequencer
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			hst_r <= H_IDLE;
			{ph_r, byt_r, len_r, bit_r, rd_r, nack_r, scl_oe_r, sda_oe_r} <= 14'h0000;
			{sh_r, dat_r, rx_r} <= 48'h000000000000;
			{RSP_VALID, RSP_NACK} <= 2'h0;
			RSP_DATA <= 16'h0000;
		end else if (CE) begin
			RSP_VALID <= 1'h0;
			unique case (hst_r)
				H_IDLE: if (CMD_VALID) begin
					{rd_r, len_r, dat_r} <= {CMD_READ, CMD_LEN, CMD_DATA};
					sh_r   <= {`DEV_ADDR_W} | {7'h00, CMD_READ};
					{ph_r, byt_r, bit_r, nack_r} <= 9'h000;
					rx_r   <= 16'h0000;
					hst_r  <= H_START;
				end
				H_START: if (qt) begin
					ph_r <= ph_r + 2'h1;
					if (ph_r == 2'h1) sda_oe_r <= 1'h1;
					if (ph_r == 2'h3) begin
						scl_oe_r <= 1'h1;
						hst_r    <= H_BIT;
					end
				end
				H_BIT: if (qt) begin
					ph_r <= ph_r + 2'h1;
					unique case (ph_r)
						2'h0: if (bit_r != 4'h8) sda_oe_r <= out_c & ~sh_r[7];
						      else sda_oe_r <= !out_c && (byt_r != len_r);
						2'h1: scl_oe_r <= 1'h0;
						2'h2: if (bit_r != 4'h8) sh_r <= {sh_r[6:0], ss};
						      else if (out_c) nack_r <= ss;
						2'h3: begin
							scl_oe_r <= 1'h1;
							if (bit_r != 4'h8) bit_r <= bit_r + 4'h1;
							else begin
								bit_r <= 4'h0;
								if (!out_c && byt_r == 2'h1) rx_r[15:8] <= sh_r;
								if (!out_c && byt_r == 2'h2) rx_r[7:0] <= sh_r;
								if (nack_r || byt_r == len_r) hst_r <= H_STOP;
								else begin
									byt_r <= byt_r + 2'h1;
									sh_r  <= pick(dat_r, byt_r + 2'h1);
								end
							end
						end
					endcase
				end
				H_STOP: if (qt) begin
					ph_r <= ph_r + 2'h1;
					if (ph_r == 2'h0) sda_oe_r <= 1'h1;
					if (ph_r == 2'h1) scl_oe_r <= 1'h0;
					if (ph_r == 2'h3) begin
						sda_oe_r  <= 1'h0;
						RSP_VALID <= 1'h1;
						RSP_DATA  <= rx_r;
						RSP_NACK  <= nack_r;
						hst_r     <= H_IDLE;
					end
				end
			endcase
		end
	end

	assign I2C.host_scl_o  = 1'h0;
	assign I2C.host_scl_oe = scl_oe_r;
	assign I2C.host_sda_o  = 1'h0;
	assign I2C.host_sda_oe = sda_oe_r;
endmodule : compass_host

// ---- bench/compass_link_properties.sv ----
`timescale 1ns/1ps
// ****************************************
// Wire checks on the two-wire link
// ****************************************
module compass_link_properties (
	// Clocks and reset
	input wire logic MCLK,
	input wire logic LCLK,
	input wire logic NRST,
	// Link signals
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic        scl_q;
	logic [15:0] per_cnt;
	logic [15:0] low_cnt;
	logic [15:0] hi_cnt;

	// Cycles since the last rising clock edge
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			scl_q   <= 1'b1;
			per_cnt <= 16'hFFFF;
		end else begin
			scl_q <= scl;
			if (scl && !scl_q)
				per_cnt <= 16'h0000;
			else if (per_cnt != 16'hFFFF)
				per_cnt <= per_cnt + 16'h0001;
		end
	end

	// Length of the current clock-low run
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			low_cnt <= 16'h0000;
		else
			low_cnt <= scl ? 16'h0000 : low_cnt + 16'h0001;
	end

	// Length of the current clock-high run, seen from the device side
	always_ff @(posedge LCLK or negedge NRST) begin
		if (!NRST)
			hi_cnt <= 16'h0000;
		else if (!scl)
			hi_cnt <= 16'h0000;
		else if (hi_cnt != 16'hFFFF)
			hi_cnt <= hi_cnt + 16'h0001;
	end

	AST_HOST_OD: assert property (@(posedge MCLK) disable iff (!NRST)
		!host_scl_o && !host_sda_o && (!$rose(host_scl_oe) || $stable(host_sda_oe)))
		else $error("host drives a line high or moves data as the clock falls");
	AST_DEV_OD: assert property (@(posedge LCLK) disable iff (!NRST)
		!dev_sda_o && !(dev_sda_oe && host_sda_oe && scl)) else $error("two drivers on data while clock high");
	AST_SCL_RATE: assert property (@(posedge MCLK) disable iff (!NRST)
		scl && !scl_q |-> per_cnt >= 16'h03DD) else $error("bit period too short");
	AST_SCL_LOW: assert property (@(posedge MCLK) disable iff (!NRST) low_cnt <= 16'h0230)
		else $error("clock held low too long");
	AST_START: assert property (@(posedge MCLK) disable iff (!NRST)
		$rose(host_sda_oe) && scl |-> ##[1:520] !scl) else $error("start not followed by clock");
	AST_STOP: assert property (@(posedge MCLK) disable iff (!NRST)
		$fell(host_sda_oe) && scl |-> (!host_sda_oe && !host_scl_oe) [*8]) else $error("bus busy after stop");
	AST_DEV_EDGE: assert property (@(posedge LCLK) disable iff (!NRST)
		$changed(dev_sda_oe) |-> !scl) else $error("device data changed with clock high");
	AST_DEV_IDLE: assert property (@(posedge LCLK) disable iff (!NRST)
		hi_cnt > 16'h03E8 |-> !dev_sda_oe) else $error("device drives an idle bus");
endmodule : compass_link_properties

// ---- bench/compass_i2c_command_mode_ctrl_tb.sv ----
`timescale 1ns/1ps
// ****************************************
// Bench: host end talks to device end
// ****************************************
module compass_i2c_command_mode_ctrl_tb;
	import compass_pkg::*;
	logic          mclk = 1'b0;
	logic          lclk = 1'b0;
	logic          nrst = 1'b0;
	logic          cmd_valid = 1'b0;
	logic          cmd_read = 1'b0;
	logic [1:0]    cmd_len = 2'h0;
	cmd_bytes_type cmd_data = 24'h000000;
	logic          rsp_valid;
	word_type      rsp_data;
	logic          rsp_nack;
	logic          meas_req;
	logic          meas_done = 1'b0;
	word_type      meas_data = 16'h0000;
	byte_type      ee_val = 8'h00;
	byte_type      op_mode;
	byte_type      mode_val;
	word_type      exp_data;
	int            nreq = 0;
	int            errors = 0;
	int            samples_checked = 0;
	integer        seed = 32'h6A5D;
	logic          cmd_ready;
	logic          sleep;
	logic          cal_mode;
	logic          sr_pulse;
	logic          ee_we;
	int            nsr = 0;
	int            ee_writes = 0;
	int            t0, n0, s0, e;
	localparam int TB_TICK = 10;
	localparam int TB_SR   = 3;

	compass_i2c_if i2c ();

	// Unrelated core and link clocks
	always #5 mclk = ~mclk;
	always #3 lclk = ~lclk;

	compass_dev #(.TICK_CYCLES(TB_TICK), .SR_PERIOD_MS(TB_SR)) i_compass_dev (
		.MCLK(mclk), .NRST(nrst), .CE(1'b1), .LCLK(lclk), .I2C(i2c),
		.MEAS_REQ(meas_req), .MEAS_DONE(meas_done), .MEAS_DATA(meas_data),
		.EE_WE(ee_we), .EE_RE(), .EE_ADDR(), .EE_WDATA(), .EE_RDATA(ee_val),
		.SLEEP(sleep), .SR_PULSE(sr_pulse), .CAL_MODE(cal_mode), .OP_MODE(op_mode));

	compass_host i_compass_host (
		.MCLK(mclk), .NRST(nrst), .CE(1'b1), .I2C(i2c), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD_READ(cmd_read), .CMD_LEN(cmd_len), .CMD_DATA(cmd_data),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_NACK(rsp_nack));

	compass_link_properties i_compass_link_properties (
		.MCLK(mclk), .LCLK(lclk), .NRST(nrst),
		.host_scl_o(i2c.host_scl_o), .host_scl_oe(i2c.host_scl_oe), .host_sda_o(i2c.host_sda_o),
		.host_sda_oe(i2c.host_sda_oe), .dev_sda_o(i2c.dev_sda_o), .dev_sda_oe(i2c.dev_sda_oe),
		.scl(i2c.scl), .sda(i2c.sda));

	// Measurement engine answers each request with a random result
	always @(posedge mclk) begin
		meas_done <= 1'b0;
		if (meas_req === 1'b1) begin
			nreq      <= nreq + 1;
			meas_done <= 1'b1;
			meas_data <= 16'($random(seed));
		end
	end

	// Count set/reset pulses and store writes
	always @(posedge mclk) begin
		if (sr_pulse === 1'b1)
			nsr <= nsr + 1;
		if (ee_we === 1'b1)
			ee_writes <= ee_writes + 1;
	end

	// Cycles between continuous measurements for a rate code
	function automatic int rate_period(input logic [1:0] sel);
		int hz;
		hz = (sel == 2'h0) ? 1 : (sel == 2'h1) ? 5 : (sel == 2'h2) ? 10 : 20;
		return TB_TICK * 1000 / hz;
	endfunction : rate_period

	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk

	// One host transfer, waited on under a bound
	task automatic xfer(input logic rd, input logic [1:0] len, input cmd_bytes_type data);
		int n;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_read  <= rd;
		cmd_len   <= len;
		cmd_data  <= data;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		@(negedge mclk);
		chk(cmd_ready === 1'b0, "ready during transfer");
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 60000);
		chk(n < 60000 && rsp_nack === 1'b0, "transfer not acknowledged");
	endtask : xfer

	task automatic close_out();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// Main sequence
	initial begin
		ee_val   <= {1'b0, 2'($random(seed)), 1'b1, 2'h0, 2'h2};
		mode_val = {1'b0, 2'($random(seed)), 3'h0, 2'h1};
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		repeat (20) @(posedge mclk);
		chk(op_mode === ee_val, "saved mode not loaded");
		t0 = int'($time);
		n0 = nreq;
		s0 = nsr;
		xfer(1'b0, 2'h3, {8'h47, 8'h74, mode_val});
		repeat (20) @(posedge mclk);
		chk(op_mode === mode_val, "mode write lost");
		e = (int'($time) - t0) / 10 / rate_period(ee_val[6:5]);
		chk(nreq - n0 >= e - 1 && nreq - n0 <= e + 1, "continuous rate wrong");
		e = (int'($time) - t0) / 10 / (TB_TICK * TB_SR);
		chk(nsr - s0 >= e - 1 && nsr - s0 <= e + 1, "periodic set/reset rate wrong");
		n0 = nreq;
		s0 = nsr;
		repeat (600) @(posedge mclk);
		chk(nreq == n0, "measured without get-data");
		xfer(1'b0, 2'h1, {8'h41, 16'h0000});
		repeat (40) @(posedge mclk);
		chk(nreq == n0 + 1, "no measurement on get-data");
		exp_data = meas_data;
		xfer(1'b1, 2'h2, 24'h000000);
		chk(rsp_data === exp_data, "read data wrong");
		repeat (200) @(posedge mclk);
		chk(nreq == n0 + 2, "no refresh after read");
		chk(nsr == s0, "set/reset with bit 4 clear");
		chk(sleep === 1'b0 && cal_mode === 1'b0 && ee_writes == 0, "stray sleep, calibration or store write");
		close_out();
	end

	// Watchdog
	initial begin
		repeat (100000) @(posedge mclk);
		errors++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		close_out();
	end
endmodule : compass_i2c_command_mode_ctrl_tb
